// >>> logic/astx_pkg.sv
// constants, field positions and types of the serial transmitter
// assumes a 32-bit apb slave port and one 40 MHz clock
package astx_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA    = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_BAUD    = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_EXTPRE  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CCODE   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_IRQPEND = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_IRQEN   = 8'h1c;

    // status, pending and enable registers share this layout
    localparam int unsigned BIT_VACANT = 0;
    localparam int unsigned BIT_DONE   = 1;

    // serial_control_reg_1 fields
    localparam int unsigned BIT_NINTH  = 0;
    localparam int unsigned BIT_WORD9  = 1;
    localparam int unsigned BIT_TXON   = 2;
    localparam int unsigned BIT_BRK    = 3;

    // cond_code_reg field
    localparam int unsigned BIT_GMASK  = 0;

    localparam int unsigned DIV_W      = 8;
    localparam int unsigned WORD_W     = 9;
    localparam int unsigned FRAME_W    = WORD_W + 2;
    localparam int unsigned CNT_W      = 4;

    localparam logic [CNT_W-1:0] LEN_8BIT = 4'ha;
    localparam logic [CNT_W-1:0] LEN_9BIT = 4'hb;

    localparam logic [DIV_W-1:0] BAUD_RST   = 8'h00;
    localparam logic [DIV_W-1:0] EXTPRE_RST = 8'h00;
    localparam logic             GMASK_RST  = 1'b1;
    localparam logic             VACANT_RST = 1'b1;
    localparam logic             DONE_RST   = 1'b1;

    typedef enum logic [1:0] {
        ASTX_FR_DATA,
        ASTX_FR_IDLE,
        ASTX_FR_BREAK
    } astx_frame_t;

    typedef enum logic {
        ASTX_SH_IDLE,
        ASTX_SH_SEND
    } astx_shstate_t;

endpackage

// >>> logic/astx_link_if.sv
// links control, shifter and bit-rate divider
// assumes all three parties run on the same clock
`timescale 1ns/1ps
interface astx_link_if;
    logic                        start;
    astx_pkg::astx_frame_t       kind;
    logic [astx_pkg::WORD_W-1:0] word;
    logic                        nineBit;
    logic                        busy;
    logic                        done;
    logic                        line;
    logic                        bitTick;

    modport ctl (output start, output kind, output word, output nineBit,
                 input busy, input done, input line);
    modport shf (input start, input kind, input word, input nineBit, input bitTick,
                 output busy, output done, output line);
    modport gen (input start, output bitTick);
endinterface

// >>> logic/astx_baud_gen.sv
// bit-rate divider: one tick per bit period of (ext+1)*(baud+1) clocks
// assumes start restarts the period
`timescale 1ns/1ps
module astx_baud_gen (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic [astx_pkg::DIV_W-1:0] baudDiv,
    input  wire logic [astx_pkg::DIV_W-1:0] extDiv,
    astx_link_if.gen                        lk
);
    logic [astx_pkg::DIV_W-1:0] preCnt_q, preCnt_d;
    logic [astx_pkg::DIV_W-1:0] mainCnt_q, mainCnt_d;
    logic                       tick_q, tick_d;

    always_comb begin
        preCnt_d  = preCnt_q;
        mainCnt_d = mainCnt_q;
        tick_d    = 1'b0;
        if (lk.start) begin
            preCnt_d  = '0;
            mainCnt_d = '0;
        end else if (preCnt_q >= extDiv) begin
            preCnt_d = '0;
            if (mainCnt_q >= baudDiv) begin
                mainCnt_d = '0;
                tick_d    = 1'b1;
            end else begin
                mainCnt_d = mainCnt_q + 1'b1;
            end
        end else begin
            preCnt_d = preCnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            preCnt_q  <= '0;
            mainCnt_q <= '0;
            tick_q    <= 1'b0;
        end else begin
            preCnt_q  <= preCnt_d;
            mainCnt_q <= mainCnt_d;
            tick_q    <= tick_d;
        end
    end

    assign lk.bitTick = tick_q;
endmodule

// >>> logic/astx_shifter.sv
// frame shifter: sends a data, idle or break frame lsb first
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
module astx_shifter (
    input  wire logic clk,
    input  wire logic sys_rst,
    astx_link_if.shf  lk
);
    astx_pkg::astx_shstate_t         st_q, st_d;
    logic [astx_pkg::FRAME_W-1:0]    frame_q, frame_d;
    logic [astx_pkg::CNT_W-1:0]      left_q, left_d;
    logic                            line_q, line_d;
    logic                            done_q, done_d;

    always_comb begin
        st_d    = st_q;
        frame_d = frame_q;
        left_d  = left_q;
        line_d  = line_q;
        done_d  = 1'b0;
        case (st_q)
            astx_pkg::ASTX_SH_IDLE: begin
                line_d = 1'b1; // RULE16
                if (lk.start) begin
                    left_d = lk.nineBit ? astx_pkg::LEN_9BIT : astx_pkg::LEN_8BIT; // RULE1 RULE12
                    case (lk.kind)
                        astx_pkg::ASTX_FR_IDLE: frame_d = '1; // RULE15 RULE4
                        astx_pkg::ASTX_FR_BREAK: begin
                            // zeros for the start and data bits, then a single stop bit
                            frame_d = '0; // RULE12 RULE15
                            if (lk.nineBit) begin
                                frame_d[astx_pkg::FRAME_W-1] = 1'b1;
                            end else begin
                                frame_d[astx_pkg::FRAME_W-2] = 1'b1;
                            end
                        end
                        default: begin
                            if (lk.nineBit) begin
                                frame_d = {1'b1, lk.word, 1'b0}; // RULE15
                            end else begin
                                frame_d = {2'b11, lk.word[astx_pkg::WORD_W-2:0], 1'b0};
                            end
                        end
                    endcase
                    line_d = (lk.kind == astx_pkg::ASTX_FR_DATA) ? 1'b0 :
                             (lk.kind == astx_pkg::ASTX_FR_IDLE);
                    st_d   = astx_pkg::ASTX_SH_SEND;
                end
            end
            astx_pkg::ASTX_SH_SEND: begin
                if (lk.bitTick) begin
                    if (left_q == 4'h1) begin
                        st_d   = astx_pkg::ASTX_SH_IDLE;
                        line_d = 1'b1;
                        done_d = 1'b1; // RULE10
                    end else begin
                        frame_d = {1'b1, frame_q[astx_pkg::FRAME_W-1:1]}; // RULE2
                        line_d  = frame_q[1];
                        left_d  = left_q - 1'b1;
                    end
                end
            end
            default: st_d = astx_pkg::ASTX_SH_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q    <= astx_pkg::ASTX_SH_IDLE;
            frame_q <= '1;
            left_q  <= '0;
            line_q  <= 1'b1;
            done_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            frame_q <= frame_d;
            left_q  <= left_d;
            line_q  <= line_d;
            done_q  <= done_d;
        end
    end

    assign lk.busy = (st_q == astx_pkg::ASTX_SH_SEND);
    assign lk.done = done_q;
    assign lk.line = line_q;
endmodule

// >>> logic/astx_top.sv
// serial transmitter: apb registers, holding buffer, flags, irq
// assumes an apb master on clk; the pin is driven while tx is on
//
// What this block does
// RULE1: 8-bit words, or 9 with the ninth from control register 1.
// RULE2: data leaves the pin lsb first.
// RULE3: software sets length, rates, then enables, then writes data.
// RULE4: enabling takes the pin and sends an idle frame first.
// RULE5: buffer-empty clears only by status access then data write.
// RULE6: buffer-empty sets as the buffer empties and a transfer begins.
// RULE7: buffer-empty irq needs its enable set and global mask clear.
// RULE8: a write during transmission waits in the holding buffer.
// RULE9: a write while idle starts at once; buffer-empty sets at once.
// RULE10: complete flag sets after a stop bit or break; irq if enabled.
// RULE11: the same sequence also clears the complete flag.
// RULE12: send-break loads a break frame as long as a word frame.
// RULE13: a blocked flag interrupt stays pending until serviced or cleared.
// RULE14: the clear sequence also drops the pending latch.
// RULE15: frame is start, data, stop; idle all ones; break zeros plus stop.
// RULE16: an idle transmitter holds the line high.
`timescale 1ns/1ps
module astx_top (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [astx_pkg::ADDR_W-1:0] paddr,
    input  wire logic [astx_pkg::DATA_W-1:0] pwdata,
    output logic      [astx_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic                             txPin,
    output logic                             txPinOe,
    output logic                             irq
);
    astx_link_if lk ();

    // register state
    logic                       ninth_q, ninth_d;
    logic                       word9_q, word9_d;
    logic                       txOn_q, txOn_d;
    logic                       brkReq_q, brkReq_d;
    logic [astx_pkg::DIV_W-1:0] baud_q, baud_d;
    logic [astx_pkg::DIV_W-1:0] extPre_q, extPre_d;
    logic                       gMask_q, gMask_d;
    logic [1:0]                 irqEn_q, irqEn_d;
    logic [1:0]                 pend_q, pend_d;
    logic                       vacant_q, vacant_d;
    logic                       done_q, done_d;
    logic                       statusSeen_q, statusSeen_d;
    // transmit control state
    logic [astx_pkg::WORD_W-2:0] hold_q, hold_d;
    logic                        holdValid_q, holdValid_d;
    logic                        pendIdle_q, pendIdle_d;
    logic                        pendBrk_q, pendBrk_d;
    logic                        start_q, start_d;
    astx_pkg::astx_frame_t       kind_q, kind_d;
    logic [astx_pkg::WORD_W-1:0] word_q, word_d;
    // bus outputs
    logic [astx_pkg::DATA_W-1:0] prdata_q, prdata_d;
    logic                        pready_q, pready_d;
    logic                        pslverr_q, pslverr_d;
    logic                        irq_q, irq_d;
    logic                        txPinOe_q;

    // bus strobes
    logic access, wrData, wrCtrl, accStatus, clearSeq, setVacant, canLaunch;

    assign access    = psel & penable & pready_q;
    assign accStatus = access & (paddr == astx_pkg::ADDR_STATUS);
    assign wrData    = access & pwrite & (paddr == astx_pkg::ADDR_DATA);
    assign wrCtrl    = access & pwrite & (paddr == astx_pkg::ADDR_CTRL1);
    assign clearSeq  = wrData & statusSeen_q; // RULE5 RULE11
    // launch only when the shifter is free, never twice in a row
    assign canLaunch = txOn_q & ~lk.busy & ~start_q;

    // transmit control
    always_comb begin
        hold_d      = hold_q;
        holdValid_d = holdValid_q;
        pendIdle_d  = pendIdle_q;
        pendBrk_d   = pendBrk_q;
        start_d     = 1'b0;
        kind_d      = kind_q;
        word_d      = word_q;
        setVacant   = 1'b0;
        if (wrCtrl && pwdata[astx_pkg::BIT_TXON] && !txOn_q) begin
            pendIdle_d = 1'b1; // RULE4
        end
        if (wrCtrl && pwdata[astx_pkg::BIT_BRK]) begin
            pendBrk_d = 1'b1; // RULE12
        end
        if (canLaunch && pendIdle_q) begin
            pendIdle_d = 1'b0;
            start_d    = 1'b1;
            kind_d     = astx_pkg::ASTX_FR_IDLE; // RULE4
        end else if (canLaunch && pendBrk_q) begin
            pendBrk_d = 1'b0;
            start_d   = 1'b1;
            kind_d    = astx_pkg::ASTX_FR_BREAK; // RULE12
        end else if (canLaunch && holdValid_q) begin
            holdValid_d = 1'b0;
            start_d     = 1'b1;
            kind_d      = astx_pkg::ASTX_FR_DATA;
            word_d      = {ninth_q, hold_q}; // RULE8 RULE1
            setVacant   = 1'b1; // RULE6
        end else if (canLaunch && wrData) begin
            start_d   = 1'b1;
            kind_d    = astx_pkg::ASTX_FR_DATA;
            word_d    = {ninth_q, pwdata[astx_pkg::WORD_W-2:0]}; // RULE9 RULE1
            setVacant = 1'b1; // RULE9
        end
        // a write not sent at once waits; a second one overwrites it
        if (wrData && !(canLaunch && !pendIdle_q && !pendBrk_q && !holdValid_q)) begin
            hold_d      = pwdata[astx_pkg::WORD_W-2:0]; // RULE8
            holdValid_d = 1'b1;
        end
        if (!txOn_q) begin
            pendIdle_d = pendIdle_d & (wrCtrl & pwdata[astx_pkg::BIT_TXON]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_q      <= '0;
            holdValid_q <= 1'b0;
            pendIdle_q  <= 1'b0;
            pendBrk_q   <= 1'b0;
            start_q     <= 1'b0;
            kind_q      <= astx_pkg::ASTX_FR_IDLE;
            word_q      <= '0;
        end else begin
            hold_q      <= hold_d;
            holdValid_q <= holdValid_d;
            pendIdle_q  <= pendIdle_d;
            pendBrk_q   <= pendBrk_d;
            start_q     <= start_d;
            kind_q      <= kind_d;
            word_q      <= word_d;
        end
    end

    // registers, flags and interrupt
    always_comb begin
        ninth_d      = ninth_q;
        word9_d      = word9_q;
        txOn_d       = txOn_q;
        brkReq_d     = brkReq_q;
        baud_d       = baud_q;
        extPre_d     = extPre_q;
        gMask_d      = gMask_q;
        irqEn_d      = irqEn_q;
        pend_d       = pend_q;
        vacant_d     = vacant_q;
        done_d       = done_q;
        statusSeen_d = statusSeen_q;
        prdata_d     = '0;
        pslverr_d    = 1'b0;
        pready_d     = psel & penable & ~pready_q;
        if (psel && penable) begin
            if (paddr == astx_pkg::ADDR_STATUS) begin
                prdata_d[astx_pkg::BIT_VACANT] = vacant_q;
                prdata_d[astx_pkg::BIT_DONE]   = done_q;
            end else if (paddr == astx_pkg::ADDR_DATA) begin
                prdata_d[astx_pkg::WORD_W-2:0] = hold_q;
            end else if (paddr == astx_pkg::ADDR_CTRL1) begin
                prdata_d[astx_pkg::BIT_NINTH] = ninth_q;
                prdata_d[astx_pkg::BIT_WORD9] = word9_q;
                prdata_d[astx_pkg::BIT_TXON]  = txOn_q;
                prdata_d[astx_pkg::BIT_BRK]   = brkReq_q;
                if (pwrite && pready_q) begin
                    ninth_d  = pwdata[astx_pkg::BIT_NINTH];
                    word9_d  = pwdata[astx_pkg::BIT_WORD9];
                    txOn_d   = pwdata[astx_pkg::BIT_TXON];
                    brkReq_d = pwdata[astx_pkg::BIT_BRK];
                end
            end else if (paddr == astx_pkg::ADDR_BAUD) begin
                prdata_d[astx_pkg::DIV_W-1:0] = baud_q;
                if (pwrite && pready_q) begin
                    baud_d = pwdata[astx_pkg::DIV_W-1:0];
                end
            end else if (paddr == astx_pkg::ADDR_EXTPRE) begin
                prdata_d[astx_pkg::DIV_W-1:0] = extPre_q;
                if (pwrite && pready_q) begin
                    extPre_d = pwdata[astx_pkg::DIV_W-1:0];
                end
            end else if (paddr == astx_pkg::ADDR_CCODE) begin
                prdata_d[astx_pkg::BIT_GMASK] = gMask_q;
                if (pwrite && pready_q) begin
                    gMask_d = pwdata[astx_pkg::BIT_GMASK];
                end
            end else if (paddr == astx_pkg::ADDR_IRQPEND) begin
                prdata_d[1:0] = pend_q;
                if (pwrite && pready_q) begin
                    pend_d = pend_q & ~pwdata[1:0];
                end
            end else if (paddr == astx_pkg::ADDR_IRQEN) begin
                prdata_d[1:0] = irqEn_q;
                if (pwrite && pready_q) begin
                    irqEn_d = pwdata[1:0];
                end
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (accStatus) begin
            statusSeen_d = 1'b1;
        end
        if (wrData) begin
            statusSeen_d = 1'b0;
        end
        if (clearSeq) begin
            vacant_d = 1'b0; // RULE5
            done_d   = 1'b0; // RULE11
            pend_d   = 2'b00; // RULE14
        end
        // hardware sets win over any clear in the same cycle
        if (setVacant) begin
            vacant_d                     = 1'b1; // RULE6 RULE9
            pend_d[astx_pkg::BIT_VACANT] = 1'b1; // RULE13
        end
        if (lk.done) begin
            done_d                     = 1'b1; // RULE10
            pend_d[astx_pkg::BIT_DONE] = 1'b1; // RULE13
        end
        if (start_q && kind_q == astx_pkg::ASTX_FR_BREAK) begin
            brkReq_d = 1'b0;
        end
        // read data and error stand only with pready
        if (pready_q) begin
            prdata_d  = '0;
            pslverr_d = 1'b0;
        end
        irq_d = |(pend_q & irqEn_q) & ~gMask_q; // RULE7 RULE10 RULE13
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ninth_q      <= 1'b0;
            word9_q      <= 1'b0;
            txOn_q       <= 1'b0;
            brkReq_q     <= 1'b0;
            baud_q       <= astx_pkg::BAUD_RST;
            extPre_q     <= astx_pkg::EXTPRE_RST;
            gMask_q      <= astx_pkg::GMASK_RST;
            irqEn_q      <= 2'b00;
            pend_q       <= 2'b00;
            vacant_q     <= astx_pkg::VACANT_RST;
            done_q       <= astx_pkg::DONE_RST;
            statusSeen_q <= 1'b0;
            prdata_q     <= '0;
            pready_q     <= 1'b0;
            pslverr_q    <= 1'b0;
            irq_q        <= 1'b0;
            txPinOe_q    <= 1'b0;
        end else begin
            ninth_q      <= ninth_d;
            word9_q      <= word9_d;
            txOn_q       <= txOn_d;
            brkReq_q     <= brkReq_d;
            baud_q       <= baud_d;
            extPre_q     <= extPre_d;
            gMask_q      <= gMask_d;
            irqEn_q      <= irqEn_d;
            pend_q       <= pend_d;
            vacant_q     <= vacant_d;
            done_q       <= done_d;
            statusSeen_q <= statusSeen_d;
            prdata_q     <= prdata_d;
            pready_q     <= pready_d;
            pslverr_q    <= pslverr_d;
            irq_q        <= irq_d;
            txPinOe_q    <= txOn_d; // RULE4
        end
    end

    assign lk.start   = start_q;
    assign lk.kind    = kind_q;
    assign lk.word    = word_q;
    assign lk.nineBit = word9_q; // RULE1

    astx_baud_gen u_baud (
        .clk     (clk),
        .sys_rst (sys_rst),
        .baudDiv (baud_q),
        .extDiv  (extPre_q),
        .lk      (lk.gen)
    );

    astx_shifter u_shift (
        .clk     (clk),
        .sys_rst (sys_rst),
        .lk      (lk.shf)
    );

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign txPin   = lk.line;
    assign txPinOe = txPinOe_q;
    assign irq     = irq_q;
endmodule

// >>> tb/astx_chk.sv
// concurrent checks on the transmitter top ports
// assumes one clock and a short bit period
`timescale 1ns/1ps
module astx_chk (
    input wire logic                        clk,
    input wire logic                        sys_rst,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [astx_pkg::ADDR_W-1:0] paddr,
    input wire logic [astx_pkg::DATA_W-1:0] pwdata,
    input wire logic [astx_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        txPin,
    input wire logic                        txPinOe,
    input wire logic                        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       acc, wrD, rdS, wrC, armQ, gmQ;
    logic [1:0] enQ, seenQ;
    logic [4:0] hiQ;
    assign acc = psel && penable && pready;
    assign wrD = acc && pwrite && paddr == astx_pkg::ADDR_DATA;
    assign rdS = acc && !pwrite && paddr == astx_pkg::ADDR_STATUS;
    assign wrC = acc && pwrite && paddr == astx_pkg::ADDR_CTRL1;
    // shadows of software writes; seen flags hold until an armed data write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armQ <= 1'b0;
            gmQ <= 1'b1;
            enQ <= 2'h0;
            seenQ <= 2'h0;
            hiQ <= 5'h00;
        end else begin
            armQ <= (acc && paddr == astx_pkg::ADDR_STATUS) ? 1'b1 : (wrD ? 1'b0 : armQ);
            gmQ <= (acc && pwrite && paddr == astx_pkg::ADDR_CCODE) ? pwdata[0] : gmQ;
            enQ <= (acc && pwrite && paddr == astx_pkg::ADDR_IRQEN) ? pwdata[1:0] : enQ;
            seenQ <= (wrD && armQ) ? 2'h0 : (rdS ? (seenQ | prdata[1:0]) : seenQ);
            hiQ <= (!txPinOe || !txPin) ? 5'h00 : ((hiQ == 5'h1f) ? hiQ : hiQ + 5'h01);
        end
    end
    a_idle_high: assert property (!txPinOe |-> txPin) else $error("line low while off");
    a_oe_on: assert property (wrC && pwdata[2] |-> ##[1:2] txPinOe) else $error("pin not taken");
    a_oe_off: assert property (wrC && !pwdata[2] |-> ##[1:2] !txPinOe) else $error("pin kept");
    a_frame_ends: assert property ($fell(txPin) |-> ##[1:40] txPin) else $error("no stop bit");
    a_idle_start: assert property (wrD && hiQ == 5'h1f |-> ##[1:3] !txPin) else $error("no start");
    a_irq_masked: assert property (gmQ && $past(gmQ, 2) |-> !irq) else $error("irq while masked");
    a_irq_enable: assert property (enQ == 2'h0 && $past(enQ, 2) == 2'h0 |-> !irq) else $error("irq off");
    a_vacant_hold: assert property (rdS && seenQ[0] |-> prdata[0]) else $error("vacant lost");
    a_done_hold: assert property (rdS && seenQ[1] |-> prdata[1]) else $error("done lost");
endmodule

// >>> tb/astx_rx_model.sv
// far-end receiver: collects each data or break frame lsb first
// assumes PER clocks per bit, the start bit one clock longer
`timescale 1ns/1ps
module astx_rx_model #(parameter int PER = 2) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        line,
    input  wire logic        nine,
    output logic      [10:0] frm,
    output int               frames
);
    logic        busyQ;
    int          t;
    logic [10:0] sh;
    always @(posedge clk) begin
        if (sys_rst) begin
            busyQ <= 1'b0;
            frames <= 0;
            frm <= 11'h000;
        end else if (!busyQ) begin
            if (line === 1'b0) begin
                busyQ <= 1'b1;
                t <= 1;
                sh <= 11'h000;
            end
        end else begin
            if (t % PER == 1) sh[t / PER] <= line;
            if (t == PER * (nine ? 10 : 9) + 1) begin
                busyQ <= 1'b0;
                frm <= sh | (11'(line) << (t / PER));
                frames <= frames + 1;
            end
            t <= t + 1;
        end
    end
endmodule

// >>> tb/tb_top.sv
// bench: registers, frames, flags, interrupt
// assumes the model runs at the programmed bit period
`timescale 1ns/1ps
module tb_top;
    localparam int PER = 2;
    localparam logic [7:0] STA = astx_pkg::ADDR_STATUS, DAT = astx_pkg::ADDR_DATA, CTL = astx_pkg::ADDR_CTRL1;
    logic        clk, sys_rst, psel, penable, pwrite, nine, pready, pslverr, txPin, txPinOe, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [10:0] frm;
    int          frames, miscompares, tests_run, cycles;
    astx_top astx_top_i (.*);
    astx_rx_model #(.PER(PER)) astx_rx_model_i (.clk(clk), .sys_rst(sys_rst), .line(txPin), .nine(nine),
        .frm(frm), .frames(frames));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r === x && e === 1'b0, m);
    endtask
    task automatic waitf(input int n);
        repeat (200) if (frames < n) @(posedge clk);
        chk(frames == n, "frame count");
    endtask
    task automatic w3();
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [10:0] fr(input logic [8:0] w, input logic n9);
        return n9 ? {1'b1, w, 1'b0} : {1'b0, 1'b1, w[7:0], 1'b0};
    endfunction
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(STA, 32'h3, "status reset");
        rd(astx_pkg::ADDR_CCODE, 32'h1, "mask reset");
        rd(astx_pkg::ADDR_IRQEN, 32'h0, "enable reset");
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(e === 1'b1 && r === 32'h0, "unmapped");
        chk(txPin === 1'b1 && txPinOe === 1'b0, "idle line");
    endtask
    task automatic t_start();
        wr(CTL, 32'h0);
        wr(astx_pkg::ADDR_BAUD, PER - 1);
        wr(astx_pkg::ADDR_EXTPRE, 32'h0);
        wr(CTL, 32'h4);
        repeat (40) @(posedge clk);
        chk(frames == 0 && txPinOe === 1'b1 && txPin === 1'b1, "idle frame");
        rd(STA, 32'h3, "idle flags");
        wr(DAT, 32'ha5);
        rd(STA, 32'h1, "launch vacant");
        waitf(1);
        chk(frm === fr(9'h0a5, 1'b0), "8-bit frame");
        rd(STA, 32'h3, "done");
    endtask
    task automatic t_pair();
        wr(DAT, 32'h81);
        rd(STA, 32'h1, "first sent");
        wr(DAT, 32'h3c);
        rd(STA, 32'h0, "second held");
        waitf(2);
        chk(frm === fr(9'h081, 1'b0), "first word");
        waitf(3);
        chk(frm === fr(9'h03c, 1'b0), "second word");
        rd(STA, 32'h3, "moved");
    endtask
    task automatic t_break();
        wr(CTL, 32'hc);
        waitf(4);
        chk(frm === 11'h200, "break frame");
        rd(CTL, 32'h4, "break done");
    endtask
    task automatic t_nine();
        nine <= 1'b1;
        wr(CTL, 32'h7);
        rd(STA, 32'h3, "flags 9-bit");
        wr(DAT, 32'h5a);
        waitf(5);
        chk(frm === fr(9'h15a, 1'b1), "9-bit frame");
    endtask
    task automatic t_irq();
        wr(astx_pkg::ADDR_IRQEN, 32'h2);
        w3();
        chk(irq === 1'b0, "masked irq");
        wr(astx_pkg::ADDR_CCODE, 32'h0);
        w3();
        chk(irq === 1'b1, "pending kept");
        rd(STA, 32'h3, "flags");
        wr(DAT, 32'h66);
        w3();
        chk(irq === 1'b0, "latch dropped");
        waitf(6);
        w3();
        chk(irq === 1'b1, "done irq");
        wr(astx_pkg::ADDR_IRQPEND, 32'h2);
        wr(astx_pkg::ADDR_IRQEN, 32'h1);
        w3();
        chk(irq === 1'b1, "vacant irq");
        wr(astx_pkg::ADDR_IRQPEND, 32'h1);
        w3();
        chk(irq === 1'b0, "pending cleared");
    endtask
    initial begin
        {sys_rst, psel, penable, pwrite, nine, paddr, pwdata} = {1'b1, 44'h0};
        {miscompares, tests_run, cycles} = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_start();
        t_pair();
        t_break();
        t_nine();
        t_irq();
        stop_test();
    end
endmodule
bind astx_top astx_chk astx_chk_i (.*);
